// ==== rtl/rcwd_cfg.svh ====
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 20 MHz core clock, 32-bit AXI4-Lite register bus
// Notes: Guarded header, definitions only
`ifndef RCWD_CFG_SVH
`define RCWD_CFG_SVH
// Register byte offsets
`define RCWD_OFF_CAUSE 8'h00
`define RCWD_OFF_CLKCTL 8'h04
`define RCWD_OFF_WAKE 8'h08
`define RCWD_OFF_IRQ_STAT 8'h0c
`define RCWD_OFF_IRQ_MASK 8'h10
// Reset cause register field positions
`define RCWD_BIT_SPLIT 7
`define RCWD_BIT_SWDIP 6
`define RCWD_BIT_RSTOP 4
`define RCWD_BIT_WDEXP 3
`define RCWD_BIT_SLEEP 2
`define RCWD_BIT_PWRUP 1
`define RCWD_BIT_DIP 0
// Clock control field positions
`define RCWD_BIT_XTAL_RDY 3
`define RCWD_BIT_OSC_STB 2
// Reset values
`define RCWD_CAUSE_RST 8'h1c
`define RCWD_OSC_FREQ_RST 3'h4
`define RCWD_DIP_SW_CFG 2'h1
// Timing in ns and clock period in ns
`define RCWD_CLK_NS 50
`define RCWD_CPU_RDY_NS 10000
`define RCWD_PLL_LOCK_NS 2000000
`define RCWD_OSC_SETTLE_NS 1000000
// Crystal start-up in oscillator periods
`define RCWD_XTAL_CYC 1024
`endif

// ==== rtl/rcwd_pkg.sv ====
// Purpose: Types shared by the reset cause and wake delay block
// Assumes: Constants live in rcwd_cfg.svh
// Notes: Nothing here is imported; use rcwd_pkg::name
package rcwd_pkg;
    // Clock source before wake
    typedef enum logic [1:0] {
        RCWD_FROM_PRIMARY,
        RCWD_FROM_SECONDARY,
        RCWD_FROM_INTERNAL,
        RCWD_FROM_SLEEP
    } rcwd_src_t;
    // Clock mode after wake
    typedef enum logic [2:0] {
        RCWD_TO_SLOW,
        RCWD_TO_MID,
        RCWD_TO_FAST,
        RCWD_TO_PLL,
        RCWD_TO_EXT,
        RCWD_TO_RC,
        RCWD_TO_INT
    } rcwd_mode_t;
    // Reset kind reported by the core
    typedef enum logic [2:0] {
        RCWD_RST_PWRUP,
        RCWD_RST_PIN_RUN,
        RCWD_RST_PIN_PM,
        RCWD_RST_WDOG,
        RCWD_RST_DIP,
        RCWD_RST_OPCODE,
        RCWD_RST_STK_FULL,
        RCWD_RST_STK_UNDER
    } rcwd_kind_t;
    // Phases of a wake
    typedef enum logic [1:0] {
        RCWD_PH_IDLE,
        RCWD_PH_XTAL,
        RCWD_PH_PLL
    } rcwd_phase_t;
    // Wake request from the core
    typedef struct packed {
        logic req;
        rcwd_src_t src;
        rcwd_mode_t mode;
    } rcwd_wake_t;
    // Reset event from the core
    typedef struct packed {
        logic valid;
        rcwd_kind_t kind;
    } rcwd_rst_t;
endpackage : rcwd_pkg

// ==== rtl/rcwd_delay.sv ====
// Purpose: Down counter that raises done after a loaded cycle count
// Assumes: Same clock as the parent; count of zero means done at once
// Notes: Small leaf used for each concurrent wake delay
`timescale 1ns/100ps
module rcwd_delay #(
    parameter int W = 24
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Control
    input wire logic load_i,
    input wire logic [W-1:0] count_i,
    // Status
    output logic done_o
);
    // Counter state
    typedef struct packed {
        logic [W-1:0] cnt;
        logic done;
    } rcwd_dly_st_t;
    rcwd_dly_st_t st_reg;
    rcwd_dly_st_t st_next;
    // Next state: load, count down, flag done at zero
    always_comb begin
        st_next = st_reg;
        if (load_i) begin
            st_next.cnt = count_i;
            st_next.done = (count_i == '0);
        end else if (st_reg.cnt != '0) begin
            st_next.cnt = st_reg.cnt - W'(1);
            st_next.done = (st_reg.cnt == W'(1));
        end
    end
    // Register the state
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_reg <= '{cnt: '0, done: 1'b1};
        end else begin
            st_reg <= st_next;
        end
    end
    assign done_o = st_reg.done;
endmodule : rcwd_delay

// ==== rtl/rcwd_top.sv ====
// Purpose: Wake exit delay timing and reset cause register
// Assumes: 20 MHz clk_i; core events synchronous to clk_i
// Notes: AXI4-Lite slave; read of irq status clears it
// How it works
// - Fixed CPU-ready delay on every wake except internal to internal, run concurrently
// - Internal oscillator frequency resets to 1 MHz
// - Crystal wake: start-up wait, then crystal ready
// - PLL wake: crystal start-up then PLL lock
// - Internal wake: run, set stable after settle
// - Eight reset causes recognised, four with a flag of their own
// - Low five bits are event flags
// - Flags readable together in one register
// - Bit 7 split enable, bit 6 dip, 5 zero
// - Watchdog flag set by powerup/clear/sleep, cleared expiry
// - Dip enable works only in config 01
// - Power-up clears powerup flag, never hardware sets
//
// Implementation choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "rcwd_cfg.svh"
module rcwd_top #(
    parameter int XTAL_CYC = `RCWD_XTAL_CYC,
    parameter int PLL_CYC = `RCWD_PLL_LOCK_NS / `RCWD_CLK_NS,
    parameter int SETTLE_CYC = `RCWD_OSC_SETTLE_NS / `RCWD_CLK_NS
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // AXI4-Lite write address and data
    input wire logic [7:0] s_awaddr_i,
    input wire logic s_awvalid_i,
    output logic s_awready_o,
    input wire logic [31:0] s_wdata_i,
    input wire logic [3:0] s_wstrb_i,
    input wire logic s_wvalid_i,
    output logic s_wready_o,
    // AXI4-Lite write response
    output logic [1:0] s_bresp_o,
    output logic s_bvalid_o,
    input wire logic s_bready_i,
    // AXI4-Lite read
    input wire logic [7:0] s_araddr_i,
    input wire logic s_arvalid_i,
    output logic s_arready_o,
    output logic [31:0] s_rdata_o,
    output logic [1:0] s_rresp_o,
    output logic s_rvalid_o,
    input wire logic s_rready_i,
    // Core events
    input wire rcwd_pkg::rcwd_wake_t wake_i,
    input wire rcwd_pkg::rcwd_rst_t rst_ev_i,
    input wire logic wdog_clear_i,
    input wire logic sleep_op_i,
    input wire logic [1:0] dip_cfg_i,
    // Core outputs
    output logic exec_ok_o,
    output logic dip_enable_o,
    output logic irq_split_o,
    output logic irq_o
);
    // Cycle counts from times, rounded up for least times
    localparam int CPU_CYC =
        (`RCWD_CPU_RDY_NS + `RCWD_CLK_NS - 1) / `RCWD_CLK_NS;
    localparam int DW = 24;

    // All state of the block
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [1:0] bresp;
        logic aw_got;
        logic w_got;
        logic [7:0] aw_addr;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic [7:0] cause;
        logic dip_sw_ok;
        logic dip_en;
        logic xtal_rdy;
        logic osc_stb;
        logic [2:0] osc_freq;
        rcwd_pkg::rcwd_phase_t phase;
        logic settling;
        logic [2:0] last_src;
        logic exec_ok;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic irq;
    } rcwd_st_t;
    rcwd_st_t st_reg;
    rcwd_st_t st_next;

    // Delay timer controls
    logic cpu_load;
    logic osc_load;
    logic [DW-1:0] osc_count;
    logic cpu_done;
    logic osc_done;

    // True when the target mode needs crystal start-up
    function automatic logic is_xtal(input rcwd_pkg::rcwd_mode_t m);
        is_xtal = (m == rcwd_pkg::RCWD_TO_SLOW) ||
                  (m == rcwd_pkg::RCWD_TO_MID) ||
                  (m == rcwd_pkg::RCWD_TO_FAST) ||
                  (m == rcwd_pkg::RCWD_TO_PLL);
    endfunction : is_xtal

    // Merge a byte-enabled write into an old word
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] be);
        merge = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                merge[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
    endfunction : merge

    // CPU-ready timer, started on every wake except internal to internal
    rcwd_delay #(.W(DW)) u_cpu_dly (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .load_i(cpu_load),
        .count_i(DW'(CPU_CYC)),
        .done_o(cpu_done)
    );
    // Oscillator timer, shared by crystal, PLL and settle phases
    rcwd_delay #(.W(DW)) u_osc_dly (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .load_i(osc_load),
        .count_i(osc_count),
        .done_o(osc_done)
    );

    // Next state
    always_comb begin
        logic wr_fire;
        logic [31:0] wv;
        logic [1:0] ev;
        rcwd_pkg::rcwd_mode_t md;
        rcwd_pkg::rcwd_src_t sr;
        wr_fire = 1'b0;
        wv = '0;
        ev = '0;
        md = wake_i.mode;
        sr = wake_i.src;
        st_next = st_reg;
        cpu_load = 1'b0;
        osc_load = 1'b0;
        osc_count = '0;

        // Write channel capture, either order
        if (s_awvalid_i && st_reg.awready) begin
            st_next.awready = 1'b0;
            st_next.aw_got = 1'b1;
            st_next.aw_addr = s_awaddr_i;
        end
        if (s_wvalid_i && st_reg.wready) begin
            st_next.wready = 1'b0;
            st_next.w_got = 1'b1;
            st_next.w_data = s_wdata_i;
            st_next.w_strb = s_wstrb_i;
        end
        // Perform write once both halves are held
        if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
            wr_fire = 1'b1;
            st_next.aw_got = 1'b0;
            st_next.w_got = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = 2'h0;
        end
        if (st_reg.bvalid && s_bready_i) begin
            st_next.bvalid = 1'b0;
            st_next.awready = 1'b1;
            st_next.wready = 1'b1;
        end
        if (wr_fire) begin
            unique case (st_reg.aw_addr)
                `RCWD_OFF_CAUSE: begin
                    // Software restores flags and control bits
                    wv = merge({24'h0, st_reg.cause}, st_reg.w_data,
                               st_reg.w_strb);
                    st_next.cause = wv[7:0];
                    st_next.cause[5] = 1'b0;
                    // Hardware owns the watchdog and sleep flags
                    st_next.cause[`RCWD_BIT_WDEXP] =
                        st_reg.cause[`RCWD_BIT_WDEXP];
                    st_next.cause[`RCWD_BIT_SLEEP] =
                        st_reg.cause[`RCWD_BIT_SLEEP];
                end
                `RCWD_OFF_CLKCTL: begin
                    // Frequency select field in bits 6:4
                    wv = merge({25'h0, st_reg.osc_freq, 4'h0},
                               st_reg.w_data, st_reg.w_strb);
                    st_next.osc_freq = wv[6:4];
                end
                `RCWD_OFF_IRQ_MASK: begin
                    wv = merge({30'h0, st_reg.irq_mask}, st_reg.w_data,
                               st_reg.w_strb);
                    st_next.irq_mask = wv[1:0];
                end
                default: begin
                    st_next.bresp = 2'h2;
                end
            endcase
        end

        // Reset cause recording
        if (rst_ev_i.valid) begin
            unique case (rst_ev_i.kind)
                rcwd_pkg::RCWD_RST_PWRUP: begin
                    st_next.cause[`RCWD_BIT_PWRUP] = 1'b0;
                    st_next.cause[`RCWD_BIT_WDEXP] = 1'b1;
                    st_next.cause[`RCWD_BIT_SLEEP] = 1'b1;
                    st_next.osc_freq = `RCWD_OSC_FREQ_RST;
                end
                rcwd_pkg::RCWD_RST_WDOG: begin
                    st_next.cause[`RCWD_BIT_WDEXP] = 1'b0;
                end
                rcwd_pkg::RCWD_RST_DIP: begin
                    st_next.cause[`RCWD_BIT_DIP] = 1'b0;
                end
                rcwd_pkg::RCWD_RST_OPCODE: begin
                    st_next.cause[`RCWD_BIT_RSTOP] = 1'b0;
                end
                rcwd_pkg::RCWD_RST_PIN_RUN,
                rcwd_pkg::RCWD_RST_PIN_PM,
                rcwd_pkg::RCWD_RST_STK_FULL,
                rcwd_pkg::RCWD_RST_STK_UNDER: begin
                    st_next.osc_freq = `RCWD_OSC_FREQ_RST;
                end
            endcase
            if (rst_ev_i.kind != rcwd_pkg::RCWD_RST_PWRUP) begin
                st_next.osc_freq = `RCWD_OSC_FREQ_RST;
            end
            ev[0] = 1'b1;
        end
        // Watchdog clear or sleep opcode sets the flag
        if (wdog_clear_i || sleep_op_i) begin
            st_next.cause[`RCWD_BIT_WDEXP] = 1'b1;
        end
        if (sleep_op_i) begin
            st_next.cause[`RCWD_BIT_SLEEP] = 1'b0;
        end
        // Dip enable only honoured in software config
        st_next.dip_sw_ok = (dip_cfg_i == `RCWD_DIP_SW_CFG);
        // Registered copy so the enable pin comes from a flop
        st_next.dip_en = st_next.cause[`RCWD_BIT_SWDIP] &&
                         st_next.dip_sw_ok;

        // Wake sequencing
        if (wake_i.req) begin
            ev[1] = 1'b1;
            st_next.exec_ok = 1'b0;
            cpu_load = 1'b1;
            st_next.settling = 1'b0;
            st_next.phase = rcwd_pkg::RCWD_PH_IDLE;
            if (sr == rcwd_pkg::RCWD_FROM_PRIMARY) begin
                // Clock kept running: CPU delay only
                st_next.xtal_rdy = (md != rcwd_pkg::RCWD_TO_INT);
                st_next.osc_stb = (md == rcwd_pkg::RCWD_TO_INT);
            end else if (is_xtal(md)) begin
                st_next.xtal_rdy = 1'b0;
                st_next.osc_stb = 1'b0;
                osc_load = 1'b1;
                osc_count = DW'(XTAL_CYC);
                st_next.phase = rcwd_pkg::RCWD_PH_XTAL;
            end else if (md == rcwd_pkg::RCWD_TO_INT) begin
                st_next.xtal_rdy = 1'b0;
                if (sr == rcwd_pkg::RCWD_FROM_INTERNAL) begin
                    // Same source: no exit delay, stable stays
                    cpu_load = 1'b0;
                    st_next.exec_ok = 1'b1;
                    // Oscillator never stopped, so it reads as settled
                    st_next.osc_stb = 1'b1;
                end else begin
                    st_next.osc_stb = 1'b0;
                    osc_load = 1'b1;
                    osc_count = DW'(SETTLE_CYC);
                    st_next.settling = 1'b1;
                end
            end else begin
                // External or RC target: CPU delay only
                st_next.xtal_rdy = 1'b1;
                st_next.osc_stb = 1'b0;
            end
        end else begin
            unique case (st_reg.phase)
                rcwd_pkg::RCWD_PH_IDLE: begin
                    if (st_reg.settling && osc_done && !osc_load) begin
                        st_next.osc_stb = 1'b1;
                        st_next.settling = 1'b0;
                    end
                end
                rcwd_pkg::RCWD_PH_XTAL: begin
                    if (osc_done) begin
                        if (st_reg.last_src[2:0] ==
                            3'(rcwd_pkg::RCWD_TO_PLL)) begin
                            osc_load = 1'b1;
                            osc_count = DW'(PLL_CYC);
                            st_next.phase = rcwd_pkg::RCWD_PH_PLL;
                        end else begin
                            st_next.xtal_rdy = 1'b1;
                            st_next.phase = rcwd_pkg::RCWD_PH_IDLE;
                        end
                    end
                end
                rcwd_pkg::RCWD_PH_PLL: begin
                    if (osc_done && !osc_load) begin
                        st_next.xtal_rdy = 1'b1;
                        st_next.phase = rcwd_pkg::RCWD_PH_IDLE;
                    end
                end
            endcase
            // Execution once CPU delay and any blocking phase end
            if (cpu_done && !st_reg.exec_ok &&
                st_reg.phase == rcwd_pkg::RCWD_PH_IDLE) begin
                st_next.exec_ok = 1'b1;
            end
        end
        if (wake_i.req) begin
            st_next.last_src = 3'(md);
        end

        // Read channel
        if (s_arvalid_i && st_reg.arready) begin
            st_next.arready = 1'b0;
            st_next.rvalid = 1'b1;
            st_next.rresp = 2'h0;
            unique case (s_araddr_i)
                `RCWD_OFF_CAUSE: begin
                    // All flags together in one word
                    st_next.rdata = {24'h0, st_reg.cause};
                    st_next.rdata[`RCWD_BIT_SWDIP] =
                        st_reg.cause[`RCWD_BIT_SWDIP] &&
                        st_reg.dip_sw_ok;
                end
                `RCWD_OFF_CLKCTL: begin
                    st_next.rdata = {25'h0, st_reg.osc_freq,
                        st_reg.xtal_rdy, st_reg.osc_stb, 2'h0};
                end
                `RCWD_OFF_WAKE: begin
                    st_next.rdata = {29'h0, st_reg.phase, st_reg.exec_ok};
                end
                `RCWD_OFF_IRQ_STAT: begin
                    st_next.rdata = {30'h0, st_reg.irq_stat};
                    st_next.irq_stat = 2'h0;
                end
                `RCWD_OFF_IRQ_MASK: begin
                    st_next.rdata = {30'h0, st_reg.irq_mask};
                end
                default: begin
                    st_next.rdata = '0;
                    st_next.rresp = 2'h2;
                end
            endcase
        end
        if (st_reg.rvalid && s_rready_i) begin
            st_next.rvalid = 1'b0;
            st_next.arready = 1'b1;
        end
        // Events win over read clear
        st_next.irq_stat = st_next.irq_stat | ev;
        st_next.irq = |(st_next.irq_stat & st_next.irq_mask);
    end

    // Register all state
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_reg <= '0;
            st_reg.awready <= 1'b1;
            st_reg.wready <= 1'b1;
            st_reg.arready <= 1'b1;
            st_reg.cause <= `RCWD_CAUSE_RST;
            st_reg.osc_freq <= `RCWD_OSC_FREQ_RST;
            st_reg.exec_ok <= 1'b1;
            st_reg.phase <= rcwd_pkg::RCWD_PH_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from state
    assign s_awready_o = st_reg.awready;
    assign s_wready_o = st_reg.wready;
    assign s_bvalid_o = st_reg.bvalid;
    assign s_bresp_o = st_reg.bresp;
    assign s_arready_o = st_reg.arready;
    assign s_rvalid_o = st_reg.rvalid;
    assign s_rdata_o = st_reg.rdata;
    assign s_rresp_o = st_reg.rresp;
    assign exec_ok_o = st_reg.exec_ok;
    assign dip_enable_o = st_reg.dip_en;
    assign irq_split_o = st_reg.cause[`RCWD_BIT_SPLIT];
    assign irq_o = st_reg.irq;

    // Wake to a clock kept running holds execution off for at least 8 cycles
    property p_cpu_delay;
        @(posedge clk_i) disable iff (srst_i)
        (wake_i.req && wake_i.src == rcwd_pkg::RCWD_FROM_PRIMARY)
        |=> !exec_ok_o [*8];
    endproperty
    a_cpu_delay: assert property (p_cpu_delay)
        else $error("exec allowed before cpu delay");

    // Internal to internal wake runs at once
    property p_int_int;
        @(posedge clk_i) disable iff (srst_i)
        (wake_i.req && wake_i.src == rcwd_pkg::RCWD_FROM_INTERNAL &&
         wake_i.mode == rcwd_pkg::RCWD_TO_INT) |=> exec_ok_o;
    endproperty
    a_int_int: assert property (p_int_int)
        else $error("internal wake delayed");

    // Watchdog reset clears its flag
    property p_wdog;
        @(posedge clk_i) disable iff (srst_i)
        (rst_ev_i.valid && rst_ev_i.kind == rcwd_pkg::RCWD_RST_WDOG &&
         !wdog_clear_i && !sleep_op_i) |=> !st_reg.cause[3];
    endproperty
    a_wdog: assert property (p_wdog)
        else $error("watchdog flag not cleared");

    // Power-up clears the power-up flag
    property p_pwrup;
        @(posedge clk_i) disable iff (srst_i)
        (rst_ev_i.valid && rst_ev_i.kind == rcwd_pkg::RCWD_RST_PWRUP)
        |=> !st_reg.cause[1];
    endproperty
    a_pwrup: assert property (p_pwrup)
        else $error("power-up flag not cleared");

    // Dip enable only out when config is software
    property p_dip;
        @(posedge clk_i) disable iff (srst_i)
        dip_enable_o |-> $past(dip_cfg_i) == `RCWD_DIP_SW_CFG;
    endproperty
    a_dip: assert property (p_dip)
        else $error("dip enable outside software config");

    // Bit 5 never set
    property p_bit5;
        @(posedge clk_i) disable iff (srst_i) !st_reg.cause[5];
    endproperty
    a_bit5: assert property (p_bit5)
        else $error("unimplemented bit set");

    // Crystal wake drops ready, which stays low for a while
    property p_xtal;
        @(posedge clk_i) disable iff (srst_i)
        (wake_i.req && wake_i.src != rcwd_pkg::RCWD_FROM_PRIMARY &&
         is_xtal(wake_i.mode)) |=> !st_reg.xtal_rdy [*8];
    endproperty
    a_xtal: assert property (p_xtal)
        else $error("crystal ready too early");

    // Settling wake from sleep does not set stable at once
    property p_settle;
        @(posedge clk_i) disable iff (srst_i)
        (wake_i.req && wake_i.src == rcwd_pkg::RCWD_FROM_SLEEP &&
         wake_i.mode == rcwd_pkg::RCWD_TO_INT) |=> !st_reg.osc_stb;
    endproperty
    a_settle: assert property (p_settle)
        else $error("stable set at once");
endmodule : rcwd_top

// ==== bench/rcwd_top_tb.sv ====
// Purpose: Self-checking bench for the reset cause and wake delay block
// Assumes: Short crystal, PLL and settle counts; CPU delay 200 cycles
// Notes: Random wake pairs from a fixed seed, corner pairs first
`timescale 1ns/100ps
`include "rcwd_cfg.svh"
// Compare, count and report at once
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
    fail_count++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module rcwd_top_tb;
    localparam int XC = 300; // Crystal start-up, above the CPU delay
    localparam int PC = 16; // Short PLL lock
    localparam int SC = 16; // Short settle time
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [7:0] s_awaddr_i = '0, s_araddr_i = '0;
    logic [31:0] s_wdata_i = '0, s_rdata_o, d;
    logic [3:0] s_wstrb_i = 4'hf;
    logic s_awvalid_i = '0, s_wvalid_i = '0, s_bready_i = '0;
    logic s_arvalid_i = '0, s_rready_i = '0, wdog_clear_i = '0;
    logic sleep_op_i = '0, a;
    logic s_awready_o, s_wready_o, s_bvalid_o, s_arready_o, s_rvalid_o;
    logic [1:0] s_bresp_o, s_rresp_o, rs, dip_cfg_i = '0;
    logic exec_ok_o, dip_enable_o, irq_split_o, irq_o;
    logic [15:0] f;
    rcwd_pkg::rcwd_wake_t wake_i = '0;
    rcwd_pkg::rcwd_rst_t rst_ev_i = '0;
    int fail_count = 0, comparisons = 0, seed = 45, n, e, s, m;
    rcwd_top #(.XTAL_CYC(XC), .PLL_CYC(PC), .SETTLE_CYC(SC)) u_dut (
        .clk_i, .srst_i, .s_awaddr_i, .s_awvalid_i, .s_awready_o,
        .s_wdata_i, .s_wstrb_i, .s_wvalid_i, .s_wready_o, .s_bresp_o,
        .s_bvalid_o, .s_bready_i, .s_araddr_i, .s_arvalid_i, .s_arready_o,
        .s_rdata_o, .s_rresp_o, .s_rvalid_o, .s_rready_i, .wake_i,
        .rst_ev_i, .wdog_clear_i, .sleep_op_i, .dip_cfg_i, .exec_ok_o,
        .dip_enable_o, .irq_split_o, .irq_o);
    // Clock, 50 ns period
    initial forever #25 clk_i = ~clk_i;
    // Expected cycles with execution held after a wake
    function automatic int exp_dly(int sv, int mv);
        if (sv == 2 && mv == 6) return 0;
        if (sv == 0 || mv >= 4) return 200;
        if (mv == 3) return XC + PC;
        return XC;
    endfunction : exp_dly
    // Mask and value of cause flags after each reset kind
    function automatic logic [15:0] flag_exp(int k);
        case (k)
            0: return 16'h0e0c;
            3: return 16'h0800;
            4: return 16'h0302;
            5: return 16'h1000;
            default: return 16'h0202;
        endcase
    endfunction : flag_exp
    // Bus write, address and data offered together
    task automatic wr(input logic [7:0] ad, input logic [31:0] v);
        s_awaddr_i <= ad;
        s_wdata_i <= v;
        s_awvalid_i <= 1'b1;
        s_wvalid_i <= 1'b1;
        s_bready_i <= 1'b1;
        do begin
            @(posedge clk_i);
            if (s_awready_o) s_awvalid_i <= 1'b0;
            if (s_wready_o) s_wvalid_i <= 1'b0;
        end while (!s_bvalid_o);
        rs = s_bresp_o;
        s_bready_i <= 1'b0;
        @(posedge clk_i);
    endtask : wr
    // Bus read into d, response into rs
    task automatic rd(input logic [7:0] ad);
        s_araddr_i <= ad;
        s_arvalid_i <= 1'b1;
        s_rready_i <= 1'b1;
        do begin
            @(posedge clk_i);
            if (s_arready_o) s_arvalid_i <= 1'b0;
        end while (!s_rvalid_o);
        d = s_rdata_o;
        rs = s_rresp_o;
        s_rready_i <= 1'b0;
        @(posedge clk_i);
    endtask : rd
    // One wake, then time the hold and check the ready bits
    task automatic wake(input int sv, input int mv);
        wake_i <= '{1'b1, rcwd_pkg::rcwd_src_t'(sv[1:0]),
                    rcwd_pkg::rcwd_mode_t'(mv[2:0])};
        @(posedge clk_i);
        wake_i <= '0;
        n = 0;
        repeat (2) @(posedge clk_i);
        while (exec_ok_o !== 1'b1 && n < 1000) begin
            @(posedge clk_i);
            n++;
        end
        e = exp_dly(sv, mv);
        `CHK(n + 4 > e && n < e + 4, 1'b1)
        repeat (SC + 4) @(posedge clk_i);
        rd(8'h04);
        if (mv < 4) `CHK(d[3], 1'b1)
        if (mv == 6) `CHK(d[2], 1'b1)
    endtask : wake
    // Verdict and end of run
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out
    // Hang guard
    initial begin
        repeat (40000) @(posedge clk_i);
        fail_count++;
        close_out();
    end
    // Main sequence
    initial begin
        repeat (3) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        rd(8'h00);
        `CHK(d[7:0], 8'h1c)
        rd(8'h04);
        `CHK(d[6:4], 3'h4)
        rd(8'h40);
        `CHK(rs, 2'b10)
        dip_cfg_i <= 2'h1;
        wr(8'h40, 32'h0);
        `CHK(rs, 2'b10)
        wr(8'h00, 32'hff);
        `CHK(rs, 2'b00)
        rd(8'h00);
        `CHK(d[7:0], 8'hdf)
        `CHK({irq_split_o, dip_enable_o}, 2'b11)
        dip_cfg_i <= 2'h2;
        repeat (2) @(posedge clk_i);
        rd(8'h00);
        `CHK({d[6], dip_enable_o}, 2'b00)
        for (int k = 0; k < 8; k++) begin
            wr(8'h00, 32'hd3);
            rst_ev_i <= '{1'b1, rcwd_pkg::rcwd_kind_t'(k)};
            @(posedge clk_i);
            rst_ev_i <= '0;
            repeat (2) @(posedge clk_i);
            rd(8'h00);
            f = flag_exp(k);
            `CHK(d[7:0] & f[15:8], f[7:0])
        end
        wdog_clear_i <= 1'b1;
        @(posedge clk_i);
        wdog_clear_i <= 1'b0;
        sleep_op_i <= 1'b1;
        @(posedge clk_i);
        sleep_op_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rd(8'h00);
        `CHK(d[3:2], 2'b10)
        rd(8'h0c);
        wr(8'h10, 32'h0);
        wake(1, 4);
        a = irq_o;
        wr(8'h10, 32'h3);
        repeat (2) @(posedge clk_i);
        `CHK(irq_o ^ a, 1'b1)
        rd(8'h0c);
        `CHK(d[1], 1'b1)
        repeat (2) @(posedge clk_i);
        `CHK(irq_o, 1'b0)
        wake(2, 6);
        wake(3, 3);
        wake(0, 0);
        for (int i = 0; i < 10; i++) begin
            s = $unsigned($random(seed)) % 4;
            m = $unsigned($random(seed)) % 7;
            wake(s, m);
        end
        close_out();
    end
endmodule : rcwd_top_tb
